// File: rtl/dac_cmd_defs.svh
// constants for the serial command decoder
// How it works
// - control write clears short-circuit flag
// - control write clears brownout flag
// - address 0010 copies input to DAC
// - 24-bit frame, bit20 zero, address, data
// - address 1011 returns DAC register next frame
// - reply: bit20 zero, address echo, data
// - address 0011 loads input and DAC
// - address 0001 loads input register only
// - address 1010 returns input register next frame
// - address 1001 data bit0 disables chaining
// - chaining off: output tristate, no readback
// - address 0111 resets data to power-up value
// - address 1111 clamps output, buffer off
// - no-op addresses leave state unchanged
// - address 1100 returns control register with flags
`ifndef DAC_CMD_DEFS_SVH
`define DAC_CMD_DEFS_SVH
// ==========================================================
// frame layout
`define FRAME_BITS 24
`define ZERO_BIT 20
`define ADDR_HI 19
`define ADDR_LO 16
`define DATA_HI 15
// ==========================================================
// command addresses
`define ADDR_WR_INPUT 4'h1
`define ADDR_UPDATE 4'h2
`define ADDR_WR_UPDATE 4'h3
`define ADDR_WR_CTRL 4'h4
`define ADDR_DATA_RESET 4'h7
`define ADDR_CHAIN 4'h9
`define ADDR_RB_INPUT 4'hA
`define ADDR_RB_DAC 4'hB
`define ADDR_RB_CTRL 4'hC
`define ADDR_FULL_RESET 4'hF
// ==========================================================
// control register fields and reset values
`define CTRL_BITS 11
`define CTRL_USED_MASK 11'h7DF
`define CTRL_RESET 11'h000
`define PV_HI 4
`define PV_LO 3
`define CODE_ZERO 16'h0000
`define CODE_MID 16'h8000
`define CODE_FULL 16'hFFFF
`define CHAIN_RESET 1'b0
`endif

// File: rtl/dac_cmd_pkg.sv
// types shared by the serial command decoder
package dac_cmd_pkg;
    typedef logic [15:0] code_type;
    typedef logic [23:0] frame_type;
    typedef enum logic [1:0]
    {
        PWR_CLAMPED = 2'b01,
        PWR_ACTIVE = 2'b10
    } power_state_type;
endpackage

// File: rtl/dac_serial_command_decoder.sv
// serial command decoder for a single-channel dac
`timescale 1ns/10ps
`include "dac_cmd_defs.svh"
module dac_serial_command_decoder #(
    parameter int CODE_WIDTH = 16
) (
    // clocks and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic serial_clk,
    // serial link
    input wire logic frame_sel_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // asynchronous pins
    input wire logic load_output_strobe_n,
    input wire logic short_detect,
    input wire logic brownout_detect,
    // converter state
    output dac_cmd_pkg::code_type dac_code,
    output dac_cmd_pkg::code_type input_code,
    output logic [`CTRL_BITS-1:0] control_bits,
    output logic short_circuit_flag,
    output logic brownout_flag,
    output logic chain_disable_bit,
    output logic output_clamped,
    output logic output_buffer_on
);
    import dac_cmd_pkg::*;

    logic rst_meta_n;
    logic rst_sync_n;
    logic [5:0] sync_q;
    logic s_word;
    logic s_excess;
    logic s_frame;
    logic s_strobe;
    logic s_short;
    logic s_brown;
    logic word_seen;
    logic excess_seen;
    logic frame_seen;
    logic strobe_seen;
    logic pending;
    logic next_pending;
    logic word_evt;
    logic excess_evt;
    logic frame_end;
    logic strobe_evt;
    logic exec;
    logic cmd_ok;
    logic [3:0] addr;
    code_type data;
    code_type pv_code;
    code_type next_dac;
    code_type next_input;
    logic [`CTRL_BITS-1:0] next_ctrl;
    logic next_sc;
    logic next_bo;
    logic next_chain;
    frame_type next_reply;
    power_state_type power;
    power_state_type next_power;

    frame_link_if link ();

    if (CODE_WIDTH != 16)
    begin : g_chk
        $error("code width must be 16");
    end

    // ==========================================================
    // reset release
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ==========================================================
    // link side and crossings
    frame_shifter #(
        .FRAME_BITS(`FRAME_BITS)
    ) u_shifter (
        .serial_clk(serial_clk),
        .rst_n(rst_sync_n),
        .frame_sel_n(frame_sel_n),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .link(link.shifter)
    );

    sync3 #(
        .WIDTH(6),
        .RST(6'h0C)
    ) u_sync (
        .clk(core_clk),
        .rst_n(rst_sync_n),
        .d({link.word_tgl, link.excess_tgl, frame_sel_n, load_output_strobe_n, short_detect, brownout_detect}),
        .q(sync_q)
    );

    assign {s_word, s_excess, s_frame, s_strobe, s_short, s_brown} = sync_q;

    assign word_evt = s_word ^ word_seen;
    assign excess_evt = s_excess ^ excess_seen;
    assign frame_end = s_frame & ~frame_seen;
    assign strobe_evt = ~s_strobe & strobe_seen;
    // a full word with no edge beyond it, acted on when select rises
    assign exec = frame_end & (pending | word_evt) & ~excess_evt;
    // the word is read only after its toggle has crossed, so it is settled
    assign addr = link.word[`ADDR_HI:`ADDR_LO];
    assign data = link.word[`DATA_HI:0];
    assign cmd_ok = ~link.word[`ZERO_BIT];

    // ==========================================================
    // frame tracking
    always_comb
    begin
        next_pending = pending;
        if (word_evt)
        begin
            next_pending = 1'b1;
        end
        if (excess_evt || frame_end)
        begin
            next_pending = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            word_seen <= 1'b0;
            excess_seen <= 1'b0;
            frame_seen <= 1'b1;
            strobe_seen <= 1'b1;
            pending <= 1'b0;
        end
        else
        begin
            word_seen <= s_word;
            excess_seen <= s_excess;
            frame_seen <= s_frame;
            strobe_seen <= s_strobe;
            pending <= next_pending;
        end
    end

    // ==========================================================
    // power-up value
    always_comb
    begin
        case (control_bits[`PV_HI:`PV_LO])
            2'b00: pv_code = `CODE_ZERO;
            2'b01: pv_code = `CODE_MID;
            default: pv_code = `CODE_FULL;
        endcase
    end

    // ==========================================================
    // command execution
    always_comb
    begin
        next_dac = dac_code;
        next_input = input_code;
        next_ctrl = control_bits;
        next_chain = chain_disable_bit;
        next_power = power;
        next_sc = short_circuit_flag;
        next_bo = brownout_flag;
        next_reply = link.reply;
        if (strobe_evt)
        begin
            next_dac = input_code;
        end
        if (exec)
        begin
            // idle frames forward what was shifted in, as in a chain
            next_reply = link.word;
        end
        if (exec && cmd_ok)
        begin
            case (addr)
                `ADDR_WR_INPUT:
                begin
                    next_input = data;
                end
                `ADDR_UPDATE:
                begin
                    next_dac = input_code;
                end
                `ADDR_WR_UPDATE:
                begin
                    next_input = data;
                    next_dac = data;
                end
                `ADDR_WR_CTRL:
                begin
                    next_ctrl = data[`CTRL_BITS-1:0] & `CTRL_USED_MASK;
                    next_sc = 1'b0;
                    next_bo = 1'b0;
                    next_power = PWR_ACTIVE;
                end
                `ADDR_DATA_RESET:
                begin
                    next_input = pv_code;
                    next_dac = pv_code;
                end
                `ADDR_CHAIN:
                begin
                    next_chain = data[0];
                end
                `ADDR_RB_INPUT:
                begin
                    if (!chain_disable_bit)
                    begin
                        next_reply = {4'h0, addr, input_code};
                    end
                end
                `ADDR_RB_DAC:
                begin
                    if (!chain_disable_bit)
                    begin
                        next_reply = {4'h0, addr, dac_code};
                    end
                end
                `ADDR_RB_CTRL:
                begin
                    if (!chain_disable_bit)
                    begin
                        next_reply = {4'h0, addr, 3'h0, short_circuit_flag, brownout_flag, control_bits};
                    end
                end
                `ADDR_FULL_RESET:
                begin
                    next_power = PWR_CLAMPED;
                    next_ctrl = `CTRL_RESET;
                    next_input = `CODE_ZERO;
                    next_dac = `CODE_ZERO;
                    next_chain = `CHAIN_RESET;
                end
                default:
                begin
                    next_dac = next_dac;
                end
            endcase
        end
        // a fault seen in the clearing cycle still sets the flag
        if (s_short)
        begin
            next_sc = 1'b1;
        end
        if (s_brown)
        begin
            next_bo = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            dac_code <= `CODE_ZERO;
            input_code <= `CODE_ZERO;
            control_bits <= `CTRL_RESET;
            chain_disable_bit <= `CHAIN_RESET;
            power <= PWR_CLAMPED;
            short_circuit_flag <= 1'b0;
            brownout_flag <= 1'b0;
            link.reply <= '0;
        end
        else
        begin
            dac_code <= next_dac;
            input_code <= next_input;
            control_bits <= next_ctrl;
            chain_disable_bit <= next_chain;
            power <= next_power;
            short_circuit_flag <= next_sc;
            brownout_flag <= next_bo;
            link.reply <= next_reply;
        end
    end

    assign output_clamped = (power == PWR_CLAMPED);
    assign output_buffer_on = (power == PWR_ACTIVE);
    // disabled chaining keeps the reply pin driver off to save power
    assign serial_out_oe = ~chain_disable_bit;

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_sync_n);

    property p_sc_clear;
        exec && cmd_ok && addr == `ADDR_WR_CTRL && !s_short |=> !short_circuit_flag;
    endproperty
    a_sc_clear: assert property (p_sc_clear) else $error("short flag not cleared");

    property p_bo_clear;
        exec && cmd_ok && addr == `ADDR_WR_CTRL && !s_brown |=> !brownout_flag;
    endproperty
    a_bo_clear: assert property (p_bo_clear) else $error("brownout flag not cleared");

    property p_update;
        exec && cmd_ok && addr == `ADDR_UPDATE |=> dac_code == $past(input_code);
    endproperty
    a_update: assert property (p_update) else $error("update did not copy input");

    property p_wr_update;
        exec && cmd_ok && addr == `ADDR_WR_UPDATE |=> dac_code == $past(data) && input_code == dac_code;
    endproperty
    a_wr_update: assert property (p_wr_update) else $error("write and update wrong");

    property p_wr_input;
        exec && cmd_ok && addr == `ADDR_WR_INPUT && !strobe_evt |=> input_code == $past(data) && $stable(dac_code);
    endproperty
    a_wr_input: assert property (p_wr_input) else $error("input write wrong");

    property p_rb_dac;
        exec && cmd_ok && addr == `ADDR_RB_DAC && !chain_disable_bit |=> link.reply == {8'h0B, $past(dac_code)};
    endproperty
    a_rb_dac: assert property (p_rb_dac) else $error("dac readback word wrong");

    property p_rb_off;
        exec && addr[3] && chain_disable_bit && addr != `ADDR_FULL_RESET |=> link.reply == $past(link.word);
    endproperty
    a_rb_off: assert property (p_rb_off) else $error("readback honoured while chain off");

    property p_chain;
        exec && cmd_ok && addr == `ADDR_CHAIN |=> chain_disable_bit == $past(data[0]) && serial_out_oe != chain_disable_bit;
    endproperty
    a_chain: assert property (p_chain) else $error("chain bit not taken");

    property p_nop;
        exec && (addr == 4'h0 || addr == 4'h5 || addr == 4'h6 || addr == 4'hD || addr == 4'hE) && !strobe_evt
            |=> $stable(dac_code) && $stable(input_code) && $stable(control_bits);
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");

    property p_full_reset;
        exec && cmd_ok && addr == `ADDR_FULL_RESET |=> output_clamped && !output_buffer_on && dac_code == `CODE_ZERO;
    endproperty
    a_full_reset: assert property (p_full_reset) else $error("full reset wrong");

    property p_data_reset;
        exec && cmd_ok && addr == `ADDR_DATA_RESET |=> dac_code == $past(pv_code);
    endproperty
    a_data_reset: assert property (p_data_reset) else $error("data reset wrong");
endmodule // dac_serial_command_decoder

// File: rtl/frame_link_if.sv
// carrier between the link-side shifter and the core
`timescale 1ns/10ps
interface frame_link_if;
    dac_cmd_pkg::frame_type word;
    logic word_tgl;
    logic excess_tgl;
    dac_cmd_pkg::frame_type reply;
    modport shifter (output word, output word_tgl, output excess_tgl, input reply);
    modport core (input word, input word_tgl, input excess_tgl, output reply);
endinterface

// File: rtl/frame_shifter.sv
// link-clock shift register for command frames and replies
`timescale 1ns/10ps
`include "dac_cmd_defs.svh"
module frame_shifter #(
    parameter int FRAME_BITS = `FRAME_BITS
) (
    // link clock and reset
    input wire logic serial_clk,
    input wire logic rst_n,
    // frame pins
    input wire logic frame_sel_n,
    input wire logic serial_in,
    output logic serial_out,
    // core side
    frame_link_if.shifter link
);
    import dac_cmd_pkg::*;

    logic [4:0] cnt;
    logic [4:0] next_cnt;
    frame_type shift;
    frame_type next_shift;
    frame_type next_word;
    logic next_word_tgl;
    logic next_excess_tgl;
    logic out_bit;
    logic next_out_bit;
    logic clr_n;

    if (FRAME_BITS != 24)
    begin : g_chk
        $error("frame length must be 24");
    end

    // the frame's own select clears the counter, so a stopped clock leaves nothing open
    assign clr_n = rst_n & ~frame_sel_n;

    // ==========================================================
    // shift in, count edges
    always_comb
    begin
        next_shift = {shift[22:0], serial_in};
        next_cnt = (cnt == 5'(FRAME_BITS)) ? cnt : cnt + 5'd1;
        next_word = link.word;
        next_word_tgl = link.word_tgl;
        next_excess_tgl = link.excess_tgl;
        if (cnt == 5'(FRAME_BITS - 1))
        begin
            next_word = next_shift;
            next_word_tgl = ~link.word_tgl;
        end
        if (cnt == 5'(FRAME_BITS))
        begin
            next_excess_tgl = ~link.excess_tgl;
        end
    end

    always_ff @(posedge serial_clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            shift <= '0;
            cnt <= '0;
        end
        else
        begin
            shift <= next_shift;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge serial_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link.word <= '0;
            link.word_tgl <= 1'b0;
            link.excess_tgl <= 1'b0;
        end
        else
        begin
            link.word <= next_word;
            link.word_tgl <= next_word_tgl;
            link.excess_tgl <= next_excess_tgl;
        end
    end

    // ==========================================================
    // reply out, msb first, changing on the falling edge
    always_comb
    begin
        next_out_bit = 1'b0;
        if (cnt < 5'(FRAME_BITS))
        begin
            next_out_bit = link.reply[5'(FRAME_BITS - 1) - cnt];
        end
    end

    always_ff @(negedge serial_clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            out_bit <= 1'b0;
        end
        else
        begin
            out_bit <= next_out_bit;
        end
    end

    // first bit must stand before the first rising edge
    assign serial_out = (cnt == 5'd0) ? link.reply[FRAME_BITS-1] : out_bit;
endmodule // frame_shifter

// File: rtl/sync3.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/10ps
module sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] f1;
    logic [WIDTH-1:0] f2;
    logic [WIDTH-1:0] f3;
    logic [WIDTH-1:0] next_q;

    if (WIDTH < 1)
    begin : g_chk
        $error("sync3 width must be positive");
    end

    // ==========================================================
    // filter: a change counts once stage two and three agree
    always_comb
    begin
        next_q = (f3 & ~(f2 ^ f3)) | (q & (f2 ^ f3));
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            f1 <= RST;
            f2 <= RST;
            f3 <= RST;
            q <= RST;
        end
        else
        begin
            f1 <= d;
            f2 <= f1;
            f3 <= f2;
            q <= next_q;
        end
    end
endmodule // sync3

// File: sim/dac_serial_command_decoder_test.sv
// self-checking bench for the serial command decoder
`timescale 1ns/10ps
`include "dac_cmd_defs.svh"
module dac_serial_command_decoder_test;
    import dac_cmd_pkg::*;
    logic core_clk, rst_n, load_output_strobe_n, short_detect, brownout_detect;
    logic serial_clk, frame_sel_n, serial_in, serial_out, serial_out_oe;
    logic serial_line;
    code_type dac_code, input_code;
    logic [`CTRL_BITS-1:0] control_bits;
    logic short_circuit_flag, brownout_flag, chain_disable_bit, output_clamped, output_buffer_on;
    frame_type reply;
    int failures = 0;
    int tests_run = 0;
    code_type pv_code [4] = '{16'h0000, 16'h8000, 16'hFFFF, 16'hFFFF};
    logic [3:0] noop_addr [5] = '{4'h0, 4'h5, 4'h6, 4'hD, 4'hE};
    // ==========================================================
    // clock and instances
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    dac_serial_command_decoder DUT (.core_clk(core_clk), .rst_n(rst_n), .serial_clk(serial_clk),
        .frame_sel_n(frame_sel_n), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .load_output_strobe_n(load_output_strobe_n),
        .short_detect(short_detect), .brownout_detect(brownout_detect), .dac_code(dac_code),
        .input_code(input_code), .control_bits(control_bits), .short_circuit_flag(short_circuit_flag),
        .brownout_flag(brownout_flag), .chain_disable_bit(chain_disable_bit),
        .output_clamped(output_clamped), .output_buffer_on(output_buffer_on));
    // a released reply pin shows the inverse, so a tristated line never passes as data
    assign serial_line = serial_out_oe ? serial_out : ~serial_out;
    host_port host (.serial_clk(serial_clk), .frame_sel_n(frame_sel_n), .serial_in(serial_in),
        .serial_out(serial_line), .reply(reply));
    // ==========================================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // effect lands 5..6 cycles after the frame; 8 also keeps frames spaced
    task automatic cmd(input logic [3:0] a, input logic [15:0] d);
        host.xfer({4'h0, a, d}, 24);
        cyc(8);
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #100000;
        failures++;
        close_out();
    end
    // ==========================================================
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        load_output_strobe_n = 1'b1;
        short_detect = 1'b0;
        brownout_detect = 1'b0;
        cyc(6);
        rst_n <= 1'b1;
        cyc(8);
        chk(chain_disable_bit, 1'b0);
        chk(serial_out_oe, 1'b1);
        chk(output_clamped, 1'b1);
        chk({short_circuit_flag, brownout_flag}, 2'b00);
        // strobe pin held low must not matter to write-and-update
        load_output_strobe_n <= 1'b0;
        cyc(8);
        cmd(4'h3, 16'hBEEF);
        load_output_strobe_n <= 1'b1;
        chk({input_code, dac_code}, {16'hBEEF, 16'hBEEF});
        cmd(4'h1, 16'h1234);
        chk({input_code, dac_code}, {16'h1234, 16'hBEEF});
        cmd(4'hB, 16'h0000);
        cmd(4'hA, 16'h0000);
        chk(reply[20:0], {1'b0, 4'hB, 16'hBEEF});
        cmd(4'h0, 16'h0000);
        chk(reply[20:0], {1'b0, 4'hA, 16'h1234});
        cmd(4'h2, 16'h0000);
        chk(dac_code, 16'h1234);
        // ==========================================================
        // fault flags, control readback and clear on control write
        short_detect <= 1'b1;
        brownout_detect <= 1'b1;
        cyc(8);
        short_detect <= 1'b0;
        brownout_detect <= 1'b0;
        cyc(8);
        chk({short_circuit_flag, brownout_flag}, 2'b11);
        cmd(4'hC, 16'h0000);
        cmd(4'h0, 16'h0000);
        chk(reply[20:0], {1'b0, 4'hC, 3'h0, 2'b11, 11'h000});
        cmd(4'h4, 16'h07FF);
        chk({short_circuit_flag, brownout_flag}, 2'b00);
        chk(control_bits, 11'h7DF);
        chk({output_clamped, output_buffer_on}, 2'b01);
        for (int p = 0; p < 4; p++)
        begin
            // range bits kept at their value, so no full reset is owed
            cmd(4'h4, {11'h000, p[1:0], 3'h7});
            cmd(4'h7, 16'h1234);
            chk({input_code, dac_code}, {pv_code[p], pv_code[p]});
        end
        // ==========================================================
        // refused frames and no-op addresses
        host.xfer({4'h0, 4'h1, 16'h0F0F}, 23);
        cyc(8);
        host.xfer({4'h1, 4'h1, 16'h0F0F}, 24);
        cyc(8);
        chk(input_code, 16'hFFFF);
        for (int i = 0; i < 5; i++)
        begin
            cmd(noop_addr[i], 16'h0F0F);
            chk({input_code, dac_code, 5'h00, control_bits}, {16'hFFFF, 16'hFFFF, 16'h001F});
        end
        // ==========================================================
        // chaining off, then on again
        cmd(4'h9, 16'h0001);
        chk({chain_disable_bit, serial_out_oe}, 2'b10);
        cmd(4'hA, 16'h0000);
        cmd(4'h0, 16'h0000);
        chk(serial_out_oe, 1'b0);
        // line released all frame, and the refused readback left only the echo behind it
        chk(reply[20:0], 21'h15FFFF);
        cmd(4'h9, 16'hFFFE);
        chk({chain_disable_bit, serial_out_oe}, 2'b01);
        // strobe pin alone copies input to dac, as the update command does
        cmd(4'h1, 16'h5A5A);
        load_output_strobe_n <= 1'b0;
        cyc(8);
        chk({input_code, dac_code}, {16'h5A5A, 16'h5A5A});
        load_output_strobe_n <= 1'b1;
        cyc(8);
        // ==========================================================
        // full reset, then the host reconfigures the range
        cmd(4'hF, 16'h0000);
        chk({output_clamped, output_buffer_on}, 2'b10);
        chk(dac_code, 16'h0000);
        cmd(4'h4, 16'h0001);
        chk({output_clamped, output_buffer_on}, 2'b01);
        chk(control_bits, 11'h001);
        close_out();
    end
endmodule // dac_serial_command_decoder_test

// File: sim/host_port.sv
// host serial port model that shifts command frames and captures replies
`timescale 1ns/10ps
module host_port (
    // frame pins
    output logic serial_clk,
    output logic frame_sel_n,
    output logic serial_in,
    // reply pin
    input wire logic serial_out,
    // reply captured during the last frame
    output dac_cmd_pkg::frame_type reply
);
    import dac_cmd_pkg::*;
    // ==========================================================
    // idle levels
    initial
    begin
        serial_clk = 1'b0;
        frame_sel_n = 1'b1;
        serial_in = 1'b0;
        reply = '0;
    end
    // ==========================================================
    // one frame, msb first; the clock stands still outside frames
    task automatic xfer(input frame_type f, input int edges);
        frame_type rx;
        rx = '0;
        // odd offset keeps the link clock out of phase with the core clock
        #1.3;
        frame_sel_n = 1'b0;
        serial_in = f[23];
        #16;
        for (int i = 0; i < edges; i++)
        begin
            serial_clk = 1'b1;
            rx = {rx[22:0], serial_out};
            #16;
            serial_clk = 1'b0;
            if (i < 23)
                serial_in = f[22-i];
            #16;
        end
        frame_sel_n = 1'b1;
        // a released line shows the inverse so a stale bit never passes as data
        serial_in = ~serial_in;
        reply = rx;
    endtask
endmodule // host_port
